// ===== rtl/mic_irq_ctrl.sv
// Interrupt controller: flags, enables, vectoring and wake-up from sleep
//
// Chosen here: the register addresses and the strobed register port.
`timescale 1ns/1ps
module mic_irq_ctrl (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Register port
    input wire logic [mic_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [mic_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [mic_pkg::DATA_W-1:0] reg_rdata,
    // Event sources
    input wire logic ext_irq_pin,
    input wire logic [mic_pkg::PORT_CHG_W-1:0] port_b_pins,
    input wire logic [mic_pkg::DATA_W-1:0] timer_zero_count,
    input wire logic [mic_pkg::PA_W-1:0] periph_req_a,
    input wire logic [mic_pkg::PB_W-1:0] periph_req_b,
    // Core sequencer
    input wire logic [mic_pkg::PC_W-1:0] cpu_pc,
    input wire logic return_from_irq_instr,
    input wire logic sleep_active,
    output logic pc_load,
    output logic [mic_pkg::PC_W-1:0] pc_load_value,
    output logic stack_push,
    output logic [mic_pkg::PC_W-1:0] stack_push_data,
    output logic wake_up,
    output logic global_irq_enable,
    // Interrupt to software
    output logic irq
);
    import mic_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [DATA_W-1:0] option_reg;
    logic [PA_W-1:0] periph_flag_reg_a;
    logic [PB_W-1:0] periph_flag_reg_b;
    logic [PA_W-1:0] periph_enable_reg_a;
    logic [PB_W-1:0] periph_enable_reg_b;
    logic [EVT_W-1:0] evt_reg;
    logic [EVT_W-1:0] evt_next;
    logic [EVT_W-1:0] evt_mask_reg;
    logic [DATA_W-1:0] t0_prev_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_load_value_reg;
    logic stack_push_reg;
    logic [PC_W-1:0] stack_push_data_reg;
    logic wake_reg;
    logic irq_reg;
    mic_state_t state_reg;
    mic_state_t state_next;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------------
    wire wr_ctrl = reg_wr && (reg_addr == ADDR_CTRL);
    wire wr_option = reg_wr && (reg_addr == ADDR_OPTION);
    wire wr_pfa = reg_wr && (reg_addr == ADDR_PFA);
    wire wr_pfb = reg_wr && (reg_addr == ADDR_PFB);
    wire wr_pea = reg_wr && (reg_addr == ADDR_PEA);
    wire wr_peb = reg_wr && (reg_addr == ADDR_PEB);
    wire wr_evt = reg_wr && (reg_addr == ADDR_EVT);
    wire wr_evt_mask = reg_wr && (reg_addr == ADDR_EVT_MASK);

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    logic ext_rise;
    logic ext_fall;
    logic [PORT_CHG_W-1:0] pb_rise;
    logic [PORT_CHG_W-1:0] pb_fall;

    // Fixed three-stage path, so latency never depends on the instruction
    mic_pin_sync u_ext_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .pin_in(ext_irq_pin),
        .level(),
        .rise(ext_rise),
        .fall(ext_fall)
    );

    genvar gi;
    generate
        for (gi = 0; gi < PORT_CHG_W; gi++) begin : g_pb_sync
            mic_pin_sync u_pb_sync (
                .sys_clk(sys_clk),
                .rst(rst),
                .pin_in(port_b_pins[gi]),
                .level(),
                .rise(pb_rise[gi]),
                .fall(pb_fall[gi])
            );
        end
    endgenerate

    wire edge_sel = option_reg[OPT_EDGE_SEL];
    wire ext_edge = edge_sel ? ext_rise : ext_fall;
    wire port_chg = |(pb_rise | pb_fall);
    wire t0_wrap = (t0_prev_reg == T0_TOP) && (timer_zero_count == T0_BOTTOM);

    // ------------------------------------------------------------------
    // Pending and take
    // ------------------------------------------------------------------
    wire core_pend = (ctrl_reg[CTRL_TMR_FLG] && ctrl_reg[CTRL_TMR_EN])
        || (ctrl_reg[CTRL_EXT_FLG] && ctrl_reg[CTRL_EXT_EN])
        || (ctrl_reg[CTRL_CHG_FLG] && ctrl_reg[CTRL_CHG_EN]);
    wire periph_pend = ctrl_reg[CTRL_GRP_EN]
        && (|(periph_flag_reg_a & periph_enable_reg_a)
        || |(periph_flag_reg_b & periph_enable_reg_b));
    wire any_pend = core_pend || periph_pend;
    // Vectoring waits until the core has left sleep, so the wake path runs first
    wire take = ctrl_reg[CTRL_GLB_EN] && any_pend && (state_reg == ST_RUN)
        && !sleep_active;
    wire wake_now = (state_reg == ST_SLEEP) && any_pend;

    // ------------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------------
    wire [DATA_W-1:0] ctrl_wval = wr_ctrl ? reg_wdata : ctrl_reg;

    // Events OR in after the write, so a set in the clearing cycle is kept
    always_comb begin
        ctrl_next = ctrl_wval;
        ctrl_next[CTRL_TMR_FLG] = ctrl_wval[CTRL_TMR_FLG] || t0_wrap;
        ctrl_next[CTRL_EXT_FLG] = ctrl_wval[CTRL_EXT_FLG] || ext_edge;
        ctrl_next[CTRL_CHG_FLG] = ctrl_wval[CTRL_CHG_FLG] || port_chg;
        if (take) begin
            ctrl_next[CTRL_GLB_EN] = 1'b0;
        end else if (return_from_irq_instr) begin
            ctrl_next[CTRL_GLB_EN] = 1'b1;
        end
    end

    wire [PA_W-1:0] pfa_next = (wr_pfa ? reg_wdata[PA_W-1:0] : periph_flag_reg_a)
        | periph_req_a;
    wire [PB_W-1:0] pfb_next = (wr_pfb ? reg_wdata[PB_W-1:0] : periph_flag_reg_b)
        | periph_req_b;

    // Sticky event status, write one to clear, set wins
    wire [EVT_W-1:0] evt_clr = wr_evt ? reg_wdata[EVT_W-1:0] : {EVT_W{1'b0}};
    wire [EVT_W-1:0] evt_set = {wake_now, take};
    wire [EVT_W-1:0] evt_mask_next = wr_evt_mask ? reg_wdata[EVT_W-1:0] : evt_mask_reg;
    assign evt_next = (evt_reg & ~evt_clr) | evt_set;

    // ------------------------------------------------------------------
    // Sleep state machine
    // ------------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN: begin
                if (sleep_active) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (any_pend) begin
                    state_next = ST_WOKE;
                end
            end
            ST_WOKE: begin
                if (!sleep_active) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_RUN;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    wire [DATA_W-1:0] rd_mux =
        (reg_addr == ADDR_CTRL) ? ctrl_reg :
        (reg_addr == ADDR_OPTION) ? option_reg :
        (reg_addr == ADDR_PFA) ? {{(DATA_W-PA_W){1'b0}}, periph_flag_reg_a} :
        (reg_addr == ADDR_PFB) ? {{(DATA_W-PB_W){1'b0}}, periph_flag_reg_b} :
        (reg_addr == ADDR_PEA) ? {{(DATA_W-PA_W){1'b0}}, periph_enable_reg_a} :
        (reg_addr == ADDR_PEB) ? {{(DATA_W-PB_W){1'b0}}, periph_enable_reg_b} :
        (reg_addr == ADDR_EVT) ? {{(DATA_W-EVT_W){1'b0}}, evt_reg} :
        (reg_addr == ADDR_EVT_MASK) ? {{(DATA_W-EVT_W){1'b0}}, evt_mask_reg} :
        {DATA_W{1'b0}};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ctrl_reg <= CTRL_RST;
            option_reg <= OPTION_RST;
            periph_flag_reg_a <= PFA_RST;
            periph_flag_reg_b <= PFB_RST;
            periph_enable_reg_a <= PFA_RST;
            periph_enable_reg_b <= PFB_RST;
            evt_reg <= EVT_RST;
            evt_mask_reg <= EVT_RST;
            t0_prev_reg <= T0_BOTTOM;
            state_reg <= ST_RUN;
        end else begin
            ctrl_reg <= ctrl_next;
            option_reg <= wr_option ? reg_wdata : option_reg;
            periph_flag_reg_a <= pfa_next;
            periph_flag_reg_b <= pfb_next;
            periph_enable_reg_a <= wr_pea ? reg_wdata[PA_W-1:0] : periph_enable_reg_a;
            periph_enable_reg_b <= wr_peb ? reg_wdata[PB_W-1:0] : periph_enable_reg_b;
            evt_reg <= evt_next;
            evt_mask_reg <= evt_mask_next;
            t0_prev_reg <= timer_zero_count;
            state_reg <= state_next;
        end
    end

    // Outputs toward the core; only the return address is saved
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pc_load_reg <= 1'b0;
            pc_load_value_reg <= PC_RST;
            stack_push_reg <= 1'b0;
            stack_push_data_reg <= PC_RST;
            wake_reg <= 1'b0;
            irq_reg <= 1'b0;
            rdata_reg <= {DATA_W{1'b0}};
        end else begin
            pc_load_reg <= take;
            pc_load_value_reg <= take ? IRQ_VECTOR : pc_load_value_reg;
            stack_push_reg <= take;
            stack_push_data_reg <= take ? cpu_pc : stack_push_data_reg;
            wake_reg <= wake_now;
            irq_reg <= |(evt_next & evt_mask_next);
            rdata_reg <= reg_rd ? rd_mux : {DATA_W{1'b0}};
        end
    end

    assign reg_rdata = rdata_reg;
    assign pc_load = pc_load_reg;
    assign pc_load_value = pc_load_value_reg;
    assign stack_push = stack_push_reg;
    assign stack_push_data = stack_push_data_reg;
    assign wake_up = wake_reg;
    assign global_irq_enable = ctrl_reg[CTRL_GLB_EN];
    assign irq = irq_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_gie_reset: assert property ($fell(rst) |-> !global_irq_enable)
        else $error("global enable set after reset");
    a_take_vector: assert property (take |=> pc_load && stack_push
        && (pc_load_value == IRQ_VECTOR))
        else $error("entry did not load vector and push");
    a_take_clears_gie: assert property (take |=> !global_irq_enable)
        else $error("global enable not cleared on entry");
    a_return_sets_gie: assert property (return_from_irq_instr && !take
        |=> global_irq_enable)
        else $error("return did not set global enable");
    a_gie_blocks: assert property (!global_irq_enable |=> !pc_load)
        else $error("vector taken with global enable clear");
    a_take_prompt: assert property (global_irq_enable && any_pend
        && (state_reg == ST_RUN) && !sleep_active |=> pc_load)
        else $error("enabled request not taken at once");
    a_t0_flag_set: assert property (t0_wrap |=> ctrl_reg[CTRL_TMR_FLG])
        else $error("timer wrap did not set flag");
    a_ext_flag_set: assert property (ext_edge |=> ctrl_reg[CTRL_EXT_FLG])
        else $error("external edge did not set flag");
    a_port_flag_set: assert property (port_chg |=> ctrl_reg[CTRL_CHG_FLG])
        else $error("port change did not set flag");
    a_flag_only_sw: assert property ($fell(ctrl_reg[CTRL_EXT_FLG])
        |-> $past(wr_ctrl && !reg_wdata[CTRL_EXT_FLG]))
        else $error("external flag cleared without a write");
    a_wake_pulse: assert property (wake_now |=> wake_up ##1 !wake_up)
        else $error("wake pulse missing or long");
    a_push_data: assert property (take |=> stack_push_data == $past(cpu_pc))
        else $error("pushed address is not the return address");

    // Flags drop only through a software write
    a_tmr_flag_sw: assert property ($fell(ctrl_reg[CTRL_TMR_FLG])
        |-> $past(wr_ctrl && !reg_wdata[CTRL_TMR_FLG]))
        else $error("timer flag dropped");
    a_chg_flag_sw: assert property ($fell(ctrl_reg[CTRL_CHG_FLG])
        |-> $past(wr_ctrl && !reg_wdata[CTRL_CHG_FLG]))
        else $error("port flag dropped");

    a_pfa_kept: assert property (!wr_pfa
        |=> &(periph_flag_reg_a | ~$past(periph_flag_reg_a)))
        else $error("flag a dropped");
    a_pfa_set: assert property (|periph_req_a
        |=> &(periph_flag_reg_a | ~$past(periph_req_a)))
        else $error("request a not flagged");

    a_ext_valid: assert property (!ext_edge && !ctrl_wval[CTRL_EXT_FLG]
        |=> !ctrl_reg[CTRL_EXT_FLG])
        else $error("flag set without valid edge");
    a_all_off: assert property (!ctrl_reg[CTRL_EXT_EN] && !ctrl_reg[CTRL_TMR_EN]
        && !ctrl_reg[CTRL_CHG_EN] && !ctrl_reg[CTRL_GRP_EN] |=> !pc_load)
        else $error("entry with enables clear");

    // Entry, sleep and read port
    a_sleep_no_take: assert property (sleep_active |=> !pc_load)
        else $error("entry while asleep");
    a_wake_needs_req: assert property (!any_pend |=> !wake_up)
        else $error("wake without a request");

    a_entry_once: assert property (pc_load |=> !pc_load)
        else $error("entry repeated");
    a_vector_hold: assert property (!take |=> $stable(pc_load_value))
        else $error("vector moved without entry");

    a_gie_steady: assert property (!take && !return_from_irq_instr && !wr_ctrl
        |=> $stable(global_irq_enable))
        else $error("global enable moved by itself");
    a_irq_level: assert property (irq == |(evt_reg & evt_mask_reg))
        else $error("irq does not follow status");

    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == {DATA_W{1'b0}})
        else $error("read data outside its cycle");

    // Main scenarios
    c_take: cover property (take ##1 pc_load);
    c_wake_inline: cover property (wake_up && !global_irq_enable);
    c_wake_then_vector: cover property (wake_now ##[1:20] take);
    c_periph_take: cover property (periph_pend && take);
    c_return: cover property (pc_load ##[1:50] return_from_irq_instr);
endmodule

// ===== rtl/mic_pin_sync.sv
// Three-stage pin synchroniser with edge detection
`timescale 1ns/1ps
module mic_pin_sync (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Pin side
    input wire logic pin_in,
    // Filtered level and edges
    output logic level,
    output logic rise,
    output logic fall
);
    logic ff1_reg;
    logic ff2_reg;
    logic ff3_reg;
    logic level_reg;
    logic primed_reg;
    // Ones shift in as the stages fill with real pin samples
    logic [2:0] fill_reg;
    wire agree = (ff2_reg == ff3_reg);
    // The first stable value after reset is taken as the start level, not an edge
    wire changed = agree && primed_reg && (ff3_reg != level_reg);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ff1_reg <= 1'b0;
            ff2_reg <= 1'b0;
            ff3_reg <= 1'b0;
            level_reg <= 1'b0;
            primed_reg <= 1'b0;
            fill_reg <= 3'h0;
        end else begin
            ff1_reg <= pin_in;
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
            fill_reg <= {fill_reg[1:0], 1'b1};
            if (agree && fill_reg[2]) begin
                level_reg <= ff3_reg;
                primed_reg <= 1'b1;
            end
        end
    end

    assign level = level_reg;
    assign rise = changed && ff3_reg;
    assign fall = changed && !ff3_reg;
endmodule

// ===== rtl/mic_pkg.sv
// Constants, register map and types of the interrupt controller
//
// Overview of operation
// - Eight sources, each with its own flag bit and its own enable bit.
// - A flag sets on its event regardless of its enable or the global enable.
// - Global enable at control bit 7 passes unmasked requests, blocks all when clear.
// - Global enable plus any core flag with its enable set, or peripheral flag with its enable and group enable set, takes the interrupt at once.
// - Every reset clears the global enable.
// - Taking an interrupt clears global enable, pushes return address, loads 0004h.
// - The return-from-interrupt instruction sets the global enable again.
// - Peripheral flags and enables sit in two register pairs, gated by group enable.
// - Pin and port-change latency is fixed, independent of instruction length.
// - External pin is edge triggered; option bit 6 picks rising or falling.
// - A valid external edge sets the external flag at control bit 1.
// - Clearing control bit 4 disables the external pin interrupt.
// - An enabled pending request wakes from sleep; global enable decides vectoring.
// - Timer-zero wrap FFh to 00h sets control bit 2; enable at bit 5.
// - A change on port B bits 7..4 sets control bit 0, gated by its enable.
// - Entry saves only the return program counter, nothing else.
// - Wake-up by interrupt with global enable set loads the vector 0004h.
package mic_pkg;
    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam int PC_W = 13;
    localparam int PA_W = 4;
    localparam int PB_W = 1;
    localparam int PORT_CHG_W = 4;
    localparam int EVT_W = 2;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_OPTION = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_PFA = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_PFB = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_PEA = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_PEB = 4'h5;
    localparam logic [ADDR_W-1:0] ADDR_EVT = 4'h6;
    localparam logic [ADDR_W-1:0] ADDR_EVT_MASK = 4'h7;

    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTRL_GLB_EN = 7;
    localparam int CTRL_GRP_EN = 6;
    localparam int CTRL_TMR_EN = 5;
    localparam int CTRL_EXT_EN = 4;
    localparam int CTRL_CHG_EN = 3;
    localparam int CTRL_TMR_FLG = 2;
    localparam int CTRL_EXT_FLG = 1;
    localparam int CTRL_CHG_FLG = 0;
    localparam int OPT_EDGE_SEL = 6;

    // Event status fields
    localparam int EVT_TAKEN = 0;
    localparam int EVT_WAKE = 1;

    // ------------------------------------------------------------------
    // Reset values and fixed numbers
    // ------------------------------------------------------------------
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
    localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
    localparam logic [PA_W-1:0] PFA_RST = 4'h0;
    localparam logic [PB_W-1:0] PFB_RST = 1'h0;
    localparam logic [EVT_W-1:0] EVT_RST = 2'h0;
    localparam logic [PC_W-1:0] PC_RST = 13'h0000;
    localparam logic [PC_W-1:0] IRQ_VECTOR = 13'h0004;
    localparam logic [DATA_W-1:0] T0_TOP = 8'hff;
    localparam logic [DATA_W-1:0] T0_BOTTOM = 8'h00;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_SLEEP,
        ST_WOKE
    } mic_state_t;
endpackage

// ===== verification/mic_core_model.sv
// Behavioural model of the core sequencer facing the interrupt controller
`timescale 1ns/1ps
module mic_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // Bench requests
    input wire logic go_sleep,
    input wire logic go_return,
    input wire logic slow_wake,
    // From the controller
    input wire logic pc_load,
    input wire logic [mic_pkg::PC_W-1:0] pc_load_value,
    input wire logic wake_up,
    // To the controller
    output logic [mic_pkg::PC_W-1:0] cpu_pc,
    output logic return_from_irq_instr,
    output logic sleep_active
);
    import mic_pkg::*;
    logic [1:0] wake_cnt;

    // ------------------------------------------------------------------
    // Program counter, return and sleep
    // ------------------------------------------------------------------
    // A slow core leaves sleep some cycles after the wake pulse
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cpu_pc <= PC_RST;
            return_from_irq_instr <= 1'b0;
            sleep_active <= 1'b0;
            wake_cnt <= 2'h0;
        end else begin
            if (pc_load) begin
                cpu_pc <= pc_load_value;
            end else if (!sleep_active) begin
                cpu_pc <= cpu_pc + 13'h0001;
            end
            return_from_irq_instr <= go_return;
            if (go_sleep) begin
                sleep_active <= 1'b1;
            end else if (wake_up) begin
                wake_cnt <= slow_wake ? 2'h3 : 2'h1;
            end else if (wake_cnt != 2'h0) begin
                wake_cnt <= wake_cnt - 2'h1;
                if (wake_cnt == 2'h1) begin
                    sleep_active <= 1'b0;
                end
            end
        end
    end
endmodule

// ===== verification/tb_top.sv
// Self-checking testbench of the interrupt controller
`timescale 1ns/1ps
module tb_top;
    import mic_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 4'h0;
    logic [DATA_W-1:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic ext_irq_pin = 1'b0;
    logic [PORT_CHG_W-1:0] port_b_pins = 4'h0;
    logic [DATA_W-1:0] timer_zero_count = 8'h00;
    logic [PA_W-1:0] periph_req_a = 4'h0;
    logic [PB_W-1:0] periph_req_b = 1'h0;
    logic go_sleep = 1'b0;
    logic go_return = 1'b0;
    logic slow_wake = 1'b0;
    logic [PC_W-1:0] cpu_pc, pc_load_value, stack_push_data, prev_pc;
    logic return_from_irq_instr, sleep_active, pc_load, stack_push;
    logic wake_up, global_irq_enable, irq;
    int errors = 0;
    int comparisons = 0;
    int n_load = 0;
    int n_wake = 0;
    int cyc = 0;
    int ld_cyc = 0;
    int d0;
    int l0;

    always #10 sys_clk = ~sys_clk;

    mic_irq_ctrl i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins),
        .timer_zero_count(timer_zero_count), .periph_req_a(periph_req_a),
        .periph_req_b(periph_req_b), .cpu_pc(cpu_pc),
        .return_from_irq_instr(return_from_irq_instr), .sleep_active(sleep_active),
        .pc_load(pc_load), .pc_load_value(pc_load_value), .stack_push(stack_push),
        .stack_push_data(stack_push_data), .wake_up(wake_up),
        .global_irq_enable(global_irq_enable), .irq(irq));

    mic_core_model i_core (.sys_clk(sys_clk), .rst(rst), .go_sleep(go_sleep),
        .go_return(go_return), .slow_wake(slow_wake), .pc_load(pc_load),
        .pc_load_value(pc_load_value), .wake_up(wake_up), .cpu_pc(cpu_pc),
        .return_from_irq_instr(return_from_irq_instr), .sleep_active(sleep_active));

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ------------------------------------------------------------------
    // Entry monitor: every vector load is checked where it stands
    // ------------------------------------------------------------------
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        prev_pc <= cpu_pc;
        if (wake_up) begin
            n_wake <= n_wake + 1;
        end
        if (pc_load) begin
            n_load <= n_load + 1;
            ld_cyc <= cyc;
            chk(16'(pc_load_value), 16'(IRQ_VECTOR));
            chk(16'(stack_push), 16'h0001);
            chk(16'(stack_push_data), 16'(prev_pc));
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk(16'(reg_rdata), 16'(e));
    endtask

    task automatic pin(input logic v, input int n);
        @(posedge sys_clk);
        ext_irq_pin <= v;
        tick(n);
    endtask

    // Stops at the first wake pulse or vector load, or after lim cycles
    task automatic wait_ev(input int lim);
        int w0;
        int p0;
        w0 = n_wake;
        p0 = n_load;
        repeat (lim) if (n_load == p0 && n_wake == w0) @(posedge sys_clk);
        #1;
    endtask

    task automatic pulse_return();
        @(posedge sys_clk);
        go_return <= 1'b1;
        @(posedge sys_clk);
        go_return <= 1'b0;
        tick(3);
    endtask

    task automatic end_sim();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        tick(2);
        chk(16'(global_irq_enable), 16'h0000);
        rd(ADDR_CTRL, CTRL_RST);
        rd(ADDR_OPTION, OPTION_RST);
        rd(4'hf, 8'h00);
        // Sources flag with every enable clear
        @(posedge sys_clk);
        timer_zero_count <= T0_TOP;
        @(posedge sys_clk);
        timer_zero_count <= T0_BOTTOM;
        tick(3);
        rd(ADDR_CTRL, 8'h04);
        pin(1'b1, 6);
        rd(ADDR_CTRL, 8'h06);
        rd(ADDR_CTRL, 8'h06);
        wr(ADDR_CTRL, 8'h00);
        wr(ADDR_OPTION, 8'hbf);
        pin(1'b0, 6);
        rd(ADDR_CTRL, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        pin(1'b1, 6);
        rd(ADDR_CTRL, 8'h00);
        @(posedge sys_clk);
        port_b_pins <= 4'h8;
        tick(6);
        rd(ADDR_CTRL, 8'h01);
        @(posedge sys_clk);
        periph_req_a <= 4'h5;
        periph_req_b <= 1'h1;
        @(posedge sys_clk);
        periph_req_a <= 4'h0;
        periph_req_b <= 1'h0;
        rd(ADDR_PFA, 8'h05);
        rd(ADDR_PFB, 8'h01);
        wr(ADDR_PFB, 8'h00);
        wr(ADDR_PFA, 8'h01);
        wr(ADDR_PEA, 8'h01);
        // Group enable gates the peripheral request
        l0 = n_load;
        wr(ADDR_CTRL, 8'h80);
        tick(8);
        chk(16'(n_load), 16'(l0));
        wr(ADDR_CTRL, 8'hc0);
        wait_ev(10);
        chk(16'(n_load), 16'(l0 + 1));
        chk(16'(global_irq_enable), 16'h0000);
        rd(ADDR_PFA, 8'h01);
        rd(ADDR_EVT, 8'h01);
        chk(16'(irq), 16'h0000);
        wr(ADDR_EVT_MASK, 8'h01);
        tick(2);
        chk(16'(irq), 16'h0001);
        wr(ADDR_EVT, 8'h01);
        tick(2);
        chk(16'(irq), 16'h0000);
        wr(ADDR_PFA, 8'h00);
        pulse_return();
        chk(16'(global_irq_enable), 16'h0001);
        tick(6);
        chk(16'(n_load), 16'(l0 + 1));
        // External enable clear blocks the pin
        wr(ADDR_CTRL, 8'h80);
        pin(1'b0, 8);
        chk(16'(n_load), 16'(l0 + 1));
        rd(ADDR_CTRL, 8'h82);
        wr(ADDR_CTRL, 8'h10);
        pin(1'b1, 6);
        wr(ADDR_CTRL, 8'h90);
        @(posedge sys_clk);
        ext_irq_pin <= 1'b0;
        d0 = cyc;
        wait_ev(12);
        chk(16'(n_load), 16'(l0 + 2));
        chk(16'(ld_cyc - d0 >= 4 && ld_cyc - d0 <= 6), 16'h0001);
        // Wake from sleep, vectoring with global enable set
        wr(ADDR_CTRL, 8'h10);
        pulse_return();
        pin(1'b1, 6);
        @(posedge sys_clk);
        go_sleep <= 1'b1;
        @(posedge sys_clk);
        go_sleep <= 1'b0;
        pin(1'b0, 0);
        wait_ev(12);
        chk(16'(n_wake), 16'h0001);
        wait_ev(12);
        chk(16'(n_load), 16'(l0 + 3));
        rd(ADDR_EVT, 8'h03);
        // Wake with global enable clear continues in line
        wr(ADDR_CTRL, 8'h10);
        pin(1'b1, 6);
        @(posedge sys_clk);
        slow_wake <= 1'b1;
        go_sleep <= 1'b1;
        @(posedge sys_clk);
        go_sleep <= 1'b0;
        pin(1'b0, 0);
        wait_ev(12);
        tick(12);
        chk(16'(n_wake), 16'h0002);
        chk(16'(n_load), 16'(l0 + 3));
        end_sim();
    end
endmodule
